// ### src/vip_cfg.svh
// timing, framing and width constants for the voice i2s audio port
`ifndef VIP_CFG_SVH
`define VIP_CFG_SVH
`define VIP_CLK_HZ 250000000
`define VIP_CLK_PERIOD_NS 4
`define VIP_BCLK_16K_HZ 1024000
`define VIP_BCLK_48K_HZ 3072000
`define VIP_BITS_PER_FRAME 64
`define VIP_SLOT_BITS 32
`define VIP_LOSS_NS 4000
`define VIP_LOSS_CYCLES (`VIP_LOSS_NS / `VIP_CLK_PERIOD_NS)
`define VIP_CMD_W 8
`define VIP_PARAM_RESET 8'h00
`endif

// ### src/vip_pkg.sv
// shared types of the voice i2s audio port
package vip_pkg;
    typedef enum logic [1:0] {LS_IDLE, LS_WAIT, LS_RUN} vip_link_state_t;
endpackage

// ### src/vip_i2s_if.sv
// serial audio link between the voice device and its host
`timescale 1ns/1ps
`default_nettype none
interface vip_i2s_if;
    // clock drivers of each end with their enables
    logic devBitClk;
    logic devBitClkOe;
    logic hostBitClk;
    logic hostBitClkOe;
    logic devFrameClk;
    logic devFrameClkOe;
    logic hostFrameClk;
    logic hostFrameClkOe;
    // resolved shared clocks
    logic bitClk;
    logic frameChannelClock;
    // data lines: reference into the device, voice out of it
    logic refSerial;
    logic voiceSerial;

    // resolve the shared clock wires from whichever end drives them
    assign bitClk = devBitClkOe ? devBitClk : (hostBitClkOe ? hostBitClk : 1'b0);
    assign frameChannelClock = devFrameClkOe ? devFrameClk :
        (hostFrameClkOe ? hostFrameClk : 1'b0);

    modport dev (
        output devBitClk, devBitClkOe, devFrameClk, devFrameClkOe, voiceSerial,
        input bitClk, frameChannelClock, refSerial
    );
    modport host (
        output hostBitClk, hostBitClkOe, hostFrameClk, hostFrameClkOe, refSerial,
        input bitClk, frameChannelClock, voiceSerial
    );
endinterface
`default_nettype wire

// ### src/vip_dev_end.sv
// device end of the voice i2s port: buffer, serial core and top
// Operation
// R1: slave variant takes clocks, sends voice, captures reference
// R2: hybrid variant masters clocks, captures reference
// R3: usb variants may master clocks, send speaker audio
// R4: one shared clock set for both directions
// R5: bit clock 1.024 or 3.072 MHz
// R6: frame clock is bit clock over 64
// R7: msb one bit clock after frame change
// R8: data in is reference, data out audio
// R9: commands before clocks run are ignored
// R10: host starts clocks before sending commands
// R11: frame low left, high right, 32 bits each
`include "vip_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// two-entry buffer with registered flags
module vip_buf2 #(
    parameter int W = 33
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    // filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    // draining side
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData
);
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic [W-1:0] head_reg;
    logic [W-1:0] tail_reg;
    logic valid_reg;
    logic ready_reg;
    logic push;
    logic pop;
    logic headFromTail;
    logic headFromIn;
    logic tailFromIn;

    // handshake decode and slot selection
    assign push = inValid && ready_reg;
    assign pop = valid_reg && outReady;
    assign cnt_next = cnt_reg + 2'(push) - 2'(pop);
    assign headFromTail = pop && (cnt_reg == 2'h2);
    assign headFromIn = push && ((cnt_reg == 2'h0) || (pop && cnt_reg == 2'h1));
    assign tailFromIn = push && ((!pop && cnt_reg == 2'h1) || (pop && cnt_reg == 2'h2));
    assign inReady = ready_reg;
    assign outValid = valid_reg;
    assign outData = head_reg;

    // occupancy and flags
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 2'h0;
            valid_reg <= 1'h0;
            ready_reg <= 1'h1;
        end else if (clkEn) begin
            cnt_reg <= cnt_next;
            valid_reg <= (cnt_next != 2'h0);
            ready_reg <= (cnt_next != 2'h2);
        end
    end

    // storage slots
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            head_reg <= '0;
            tail_reg <= '0;
        end else if (clkEn) begin
            if (headFromTail) begin
                head_reg <= tail_reg;
            end else if (headFromIn) begin
                head_reg <= inData;
            end
            if (tailFromIn) begin
                tail_reg <= inData;
            end
        end
    end
endmodule

// serial framing engine of both ends
module vip_serial_core #(
    parameter int SLOT_W = `VIP_SLOT_BITS,
    parameter int LOSS_CYCLES = `VIP_LOSS_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    // mode, change only while enable is low
    input wire logic enable,
    input wire logic master,
    input wire logic rate48k,
    // link pins
    input wire logic bclkIn,
    input wire logic frameIn,
    input wire logic sdIn,
    output logic bclkOut,
    output logic bclkOe,
    output logic frameOut,
    output logic frameOe,
    output logic sdOut,
    // words to send, each into the next channel slot, left or right
    input wire logic txValid,
    output logic txReady,
    input wire logic [SLOT_W-1:0] txData,
    // words received, channel bit on top
    output logic rxValid,
    input wire logic rxReady,
    output logic [SLOT_W:0] rxData,
    // status pulses and level
    output logic linkRunning,
    output logic rxOverrun,
    output logic txUnderrun
);
    localparam int CNT_W = $clog2(`VIP_BITS_PER_FRAME);
    localparam int LOSS_W = $clog2(LOSS_CYCLES + 1);
    localparam logic [31:0] STEP16 =
        32'((64'h2 * `VIP_BCLK_16K_HZ * (64'h1 << 32)) / `VIP_CLK_HZ);
    localparam logic [31:0] STEP48 =
        32'((64'h2 * `VIP_BCLK_48K_HZ * (64'h1 << 32)) / `VIP_CLK_HZ);

    vip_pkg::vip_link_state_t state_reg;
    vip_pkg::vip_link_state_t state_next;
    logic [31:0] nco_reg;
    logic [32:0] ncoSum;
    logic ncoCarry;
    logic [2:0] bclkSync_reg;
    logic [1:0] frameSync_reg;
    logic [1:0] sdSync_reg;
    logic [CNT_W-1:0] bitCnt_reg;
    logic [CNT_W-1:0] bitCntInc;
    logic [LOSS_W-1:0] loss_reg;
    logic bclk_reg;
    logic frame_reg;
    logic oe_reg;
    logic sd_reg;
    logic lrLast_reg;
    logic loadPending_reg;
    logic [SLOT_W-1:0] rxShift_reg;
    logic [SLOT_W-1:0] txShift_reg;
    logic running_reg;
    logic overrun_reg;
    logic underrun_reg;
    logic bitRise;
    logic bitFall;
    logic lrNow;
    logic frameEdge;
    logic lossHit;
    logic inRun;
    logic rxPush;
    logic rxInReady;
    logic txSlot;
    logic txHeadValid;
    logic [SLOT_W-1:0] txHead;

    // bit clock generator: phase accumulator toggles at twice the bit rate
    assign ncoSum = {1'b0, nco_reg} + {1'b0, (rate48k ? STEP48 : STEP16)}; // see R5
    assign ncoCarry = master && enable && ncoSum[32];
    assign bitCntInc = bitCnt_reg + CNT_W'(1);

    // one edge source for both directions, own or partner clock
    assign bitRise = master ? (ncoCarry && !bclk_reg) : (bclkSync_reg[1] && !bclkSync_reg[2]); // see R4
    assign bitFall = master ? (ncoCarry && bclk_reg) : (!bclkSync_reg[1] && bclkSync_reg[2]);
    assign lrNow = master ? frame_reg : frameSync_reg[1];
    assign frameEdge = bitRise && (lrNow != lrLast_reg);
    assign lossHit = !master && (loss_reg == LOSS_W'(LOSS_CYCLES));
    assign inRun = (state_reg == vip_pkg::LS_RUN);
    assign rxPush = frameEdge && inRun;
    assign txSlot = bitFall && loadPending_reg && inRun;

    // pin outputs and status straight from flops
    assign bclkOut = bclk_reg;
    assign frameOut = frame_reg;
    assign bclkOe = oe_reg;
    assign frameOe = oe_reg;
    assign sdOut = sd_reg;
    assign linkRunning = running_reg;
    assign rxOverrun = overrun_reg;
    assign txUnderrun = underrun_reg;

    // link state: wait for a frame change, drop out when the clock stops
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            vip_pkg::LS_IDLE: begin
                if (enable) begin
                    state_next = vip_pkg::LS_WAIT;
                end
            end
            vip_pkg::LS_WAIT: begin
                if (!enable) begin
                    state_next = vip_pkg::LS_IDLE;
                end else if (frameEdge) begin
                    state_next = vip_pkg::LS_RUN;
                end
            end
            vip_pkg::LS_RUN: begin
                if (!enable) begin
                    state_next = vip_pkg::LS_IDLE;
                end else if (lossHit) begin
                    state_next = vip_pkg::LS_WAIT;
                end
            end
            default: begin
                state_next = vip_pkg::LS_IDLE;
            end
        endcase
    end

    // pin synchronisers, clock generator, frame counter, watchdog
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bclkSync_reg <= 3'h0;
            frameSync_reg <= 2'h0;
            sdSync_reg <= 2'h0;
            nco_reg <= 32'h0;
            bclk_reg <= 1'h0;
            frame_reg <= 1'h0;
            oe_reg <= 1'h0;
            bitCnt_reg <= '1;
            loss_reg <= '0;
            state_reg <= vip_pkg::LS_IDLE;
            running_reg <= 1'h0;
        end else if (clkEn) begin
            bclkSync_reg <= {bclkSync_reg[1:0], bclkIn};
            frameSync_reg <= {frameSync_reg[0], frameIn};
            sdSync_reg <= {sdSync_reg[0], sdIn};
            oe_reg <= master && enable; // see R2 R3
            nco_reg <= (master && enable) ? ncoSum[31:0] : 32'h0;
            state_reg <= state_next;
            running_reg <= (state_next == vip_pkg::LS_RUN);
            loss_reg <= (bitRise || !enable) ? '0 : (lossHit ? loss_reg : loss_reg + LOSS_W'(1));
            if (!(master && enable)) begin
                bclk_reg <= 1'h0;
                frame_reg <= 1'h0;
                bitCnt_reg <= '1;
            end else if (ncoCarry) begin
                bclk_reg <= !bclk_reg;
                if (bclk_reg) begin
                    bitCnt_reg <= bitCntInc; // see R6
                    frame_reg <= bitCntInc[CNT_W-1]; // see R11
                end
            end
        end
    end

    // receive: shift on rising edges, word closes with the frame change
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lrLast_reg <= 1'h0;
            rxShift_reg <= '0;
            overrun_reg <= 1'h0;
        end else if (clkEn) begin
            overrun_reg <= rxPush && !rxInReady;
            if (bitRise) begin
                lrLast_reg <= lrNow;
                rxShift_reg <= {rxShift_reg[SLOT_W-2:0], sdSync_reg[1]}; // see R1 R8
            end
        end
    end

    // transmit: msb on the first falling edge after the frame change
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            loadPending_reg <= 1'h0;
            txShift_reg <= '0;
            sd_reg <= 1'h0;
            underrun_reg <= 1'h0;
        end else if (clkEn) begin
            underrun_reg <= txSlot && !txHeadValid;
            if (!enable || state_next != vip_pkg::LS_RUN) begin
                loadPending_reg <= 1'h0;
                txShift_reg <= '0;
                sd_reg <= 1'h0;
            end else if (frameEdge) begin
                loadPending_reg <= 1'h1; // see R7
            end else if (txSlot) begin
                loadPending_reg <= 1'h0;
                sd_reg <= txHeadValid && txHead[SLOT_W-1]; // see R1 R3
                txShift_reg <= txHeadValid ? {txHead[SLOT_W-2:0], 1'b0} : '0;
            end else if (bitFall) begin
                sd_reg <= txShift_reg[SLOT_W-1];
                txShift_reg <= {txShift_reg[SLOT_W-2:0], 1'b0};
            end
        end
    end

    // received words tagged with their channel
    vip_buf2 #(.W(SLOT_W + 1)) rxBuf (
        .clock(clock),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .inValid(rxPush),
        .inReady(rxInReady),
        .inData({lrLast_reg, rxShift_reg[SLOT_W-2:0], sdSync_reg[1]}),
        .outValid(rxValid),
        .outReady(rxReady),
        .outData(rxData)
    );

    // words to send, drained one per channel slot
    vip_buf2 #(.W(SLOT_W)) txBuf (
        .clock(clock),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .inValid(txValid),
        .inReady(txReady),
        .inData(txData),
        .outValid(txHeadValid),
        .outReady(txSlot),
        .outData(txHead)
    );
endmodule

// device end: voice out, reference in, command gate on running clocks
module vip_dev_end #(
    parameter int SLOT_W = `VIP_SLOT_BITS,
    parameter int LOSS_CYCLES = `VIP_LOSS_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    // mode
    input wire logic enable,
    input wire logic master,
    input wire logic rate48k,
    // link
    vip_i2s_if.dev link,
    // processed voice to send
    input wire logic voiceValid,
    output logic voiceReady,
    input wire logic [SLOT_W-1:0] voiceData,
    // reference audio received, channel bit on top
    output logic refValid,
    input wire logic refReady,
    output logic [SLOT_W:0] refData,
    // control commands
    input wire logic cmdValid,
    input wire logic [`VIP_CMD_W-1:0] cmdData,
    output logic [`VIP_CMD_W-1:0] paramValue,
    output logic cmdAccepted,
    output logic cmdIgnored,
    // status
    output logic linkRunning,
    output logic refOverrun,
    output logic voiceUnderrun
);
    logic [`VIP_CMD_W-1:0] param_reg;
    logic accepted_reg;
    logic ignored_reg;

    assign paramValue = param_reg;
    assign cmdAccepted = accepted_reg;
    assign cmdIgnored = ignored_reg;

    // commands take effect only once the link clocks are running
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            param_reg <= `VIP_PARAM_RESET;
            accepted_reg <= 1'h0;
            ignored_reg <= 1'h0;
        end else if (clkEn) begin
            accepted_reg <= cmdValid && linkRunning;
            ignored_reg <= cmdValid && !linkRunning; // see R9
            if (cmdValid && linkRunning) begin
                param_reg <= cmdData;
            end
        end
    end

    // serial engine: data in carries reference, data out carries voice
    vip_serial_core #(.SLOT_W(SLOT_W), .LOSS_CYCLES(LOSS_CYCLES)) core (
        .clock(clock),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .enable(enable),
        .master(master),
        .rate48k(rate48k),
        .bclkIn(link.bitClk),
        .frameIn(link.frameChannelClock),
        .sdIn(link.refSerial),
        .bclkOut(link.devBitClk),
        .bclkOe(link.devBitClkOe),
        .frameOut(link.devFrameClk),
        .frameOe(link.devFrameClkOe),
        .sdOut(link.voiceSerial),
        .txValid(voiceValid),
        .txReady(voiceReady),
        .txData(voiceData),
        .rxValid(refValid),
        .rxReady(refReady),
        .rxData(refData),
        .linkRunning(linkRunning),
        .rxOverrun(refOverrun),
        .txUnderrun(voiceUnderrun)
    );
endmodule
`default_nettype wire

// ### src/vip_host_end.sv
// host end of the voice i2s port: sends reference, receives voice
`include "vip_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module vip_host_end #(
    parameter int SLOT_W = `VIP_SLOT_BITS,
    parameter int LOSS_CYCLES = `VIP_LOSS_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    // mode: master high when the host makes the clocks
    input wire logic enable,
    input wire logic master,
    input wire logic rate48k,
    // link
    vip_i2s_if.host link,
    // reference audio to send
    input wire logic refValid,
    output logic refReady,
    input wire logic [SLOT_W-1:0] refData,
    // voice audio received, channel bit on top
    output logic voiceValid,
    input wire logic voiceReady,
    output logic [SLOT_W:0] voiceData,
    // status; commands should wait for linkRunning
    output logic linkRunning,
    output logic voiceOverrun,
    output logic refUnderrun
);
    // engine with data roles reversed
    vip_serial_core #(.SLOT_W(SLOT_W), .LOSS_CYCLES(LOSS_CYCLES)) core (
        .clock(clock),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .enable(enable),
        .master(master),
        .rate48k(rate48k),
        .bclkIn(link.bitClk),
        .frameIn(link.frameChannelClock),
        .sdIn(link.voiceSerial),
        .bclkOut(link.hostBitClk),
        .bclkOe(link.hostBitClkOe),
        .frameOut(link.hostFrameClk),
        .frameOe(link.hostFrameClkOe),
        .sdOut(link.refSerial),
        .txValid(refValid),
        .txReady(refReady),
        .txData(refData),
        .rxValid(voiceValid),
        .rxReady(voiceReady),
        .rxData(voiceData),
        .linkRunning(linkRunning),
        .rxOverrun(voiceOverrun),
        .txUnderrun(refUnderrun)
    );
endmodule
`default_nettype wire

// ### verification/vip_link_props.sv
// checker on the serial link joining the device and host ends
`timescale 1ns/1ps
`default_nettype none
module vip_link_props (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // link signals
    input wire logic devBitClkOe,
    input wire logic hostBitClkOe,
    input wire logic devFrameClkOe,
    input wire logic hostFrameClkOe,
    input wire logic bitClk,
    input wire logic frameChannelClock,
    input wire logic refSerial,
    input wire logic voiceSerial
);
    logic anyOe;
    logic bitPrev_reg;
    logic framePrev_reg;
    logic primed_reg;
    logic [6:0] rises_reg;
    logic [7:0] hiLen_reg;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    assign anyOe = devFrameClkOe | hostFrameClkOe;
    // bit clock high length and rises per frame half
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bitPrev_reg <= 1'b0;
            framePrev_reg <= 1'b0;
            primed_reg <= 1'b0;
            rises_reg <= 7'h00;
            hiLen_reg <= 8'h00;
        end else begin
            bitPrev_reg <= bitClk;
            framePrev_reg <= frameChannelClock;
            hiLen_reg <= bitClk ? hiLen_reg + 8'h01 : 8'h00;
            if (!anyOe) begin
                primed_reg <= 1'b0;
                rises_reg <= 7'h00;
            end else if (frameChannelClock != framePrev_reg) begin
                primed_reg <= 1'b1;
                rises_reg <= 7'h00;
            end else if (bitClk && !bitPrev_reg) begin
                rises_reg <= rises_reg + 7'h01;
            end
        end
    end
    a_one_bit_master: assert property (!(devBitClkOe && hostBitClkOe))
        else $error("both ends drive the bit clock");
    a_frame_on_fall: assert property (anyOe && $past(anyOe) && $changed(frameChannelClock) |-> $fell(bitClk))
        else $error("frame clock moved away from a bit clock fall");
    a_half_frame_length: assert property (anyOe && $past(anyOe) && primed_reg && $changed(frameChannelClock) |-> rises_reg == 7'h20)
        else $error("frame half did not hold 32 bit clocks");
    a_bit_high_length: assert property ($fell(bitClk) && (devBitClkOe || hostBitClkOe) |-> hiLen_reg inside {[8'h27:8'h29], [8'h79:8'h7B]})
        else $error("bit clock high phase off rate");
    a_voice_on_fall: assert property (devBitClkOe && $past(devBitClkOe) && $changed(voiceSerial) |-> $fell(bitClk))
        else $error("voice data moved away from a bit clock fall");
    a_ref_on_fall: assert property (hostBitClkOe && $past(hostBitClkOe) && $changed(refSerial) |-> $fell(bitClk))
        else $error("reference data moved away from a bit clock fall");
    a_ref_low_phase: assert property (devBitClkOe && $past(devBitClkOe, 4) && $changed(refSerial) |-> !bitClk)
        else $error("reference data moved while bit clock high");
    a_voice_low_phase: assert property (hostBitClkOe && $past(hostBitClkOe, 4) && $changed(voiceSerial) |-> !bitClk)
        else $error("voice data moved while bit clock high");
    // main scenarios reached
    c_dev_frames: cover property (devFrameClkOe && $changed(frameChannelClock));
    c_host_frames: cover property (hostFrameClkOe && $changed(frameChannelClock));
    c_voice_bits: cover property ($rose(voiceSerial));
    c_ref_bits: cover property ($rose(refSerial));
endmodule
`default_nettype wire

// ### verification/voice_i2s_audio_port_test.sv
// testbench joining the device and host ends over the serial link
`timescale 1ns/1ps
`default_nettype none
`include "vip_cfg.svh"
module voice_i2s_audio_port_test;
    localparam int LOSS = 400;
    localparam int F16 = int'(64'(`VIP_CLK_HZ) * `VIP_BITS_PER_FRAME / `VIP_BCLK_16K_HZ);
    localparam int F48 = int'(64'(`VIP_CLK_HZ) * `VIP_BITS_PER_FRAME / `VIP_BCLK_48K_HZ);
    // controls, user-side streams and status
    logic clock, rst_n, clkEn, dEn, dMaster, dRate, hEn, hMaster, hRate;
    logic dTxValid, dTxReady, dRxValid, dRxReady, hTxValid, hTxReady, hRxValid, hRxReady;
    logic [31:0] dTxData, hTxData;
    logic [32:0] dRxData, hRxData;
    logic cmdValid, cmdAccepted, cmdIgnored, dRun, hRun, dOvr, dUnd, hOvr, hUnd;
    logic [7:0] cmdData, paramValue;
    logic [32:0] dQ[$], hQ[$];
    int fail_count = 0, n_tests = 0, ovrSeen = 0;
    vip_i2s_if link();
    vip_dev_end #(.LOSS_CYCLES(LOSS)) vip_dev_end_i (.clock(clock), .rst_n(rst_n),
        .clkEn(clkEn), .enable(dEn), .master(dMaster), .rate48k(dRate), .link(link),
        .voiceValid(dTxValid), .voiceReady(dTxReady), .voiceData(dTxData),
        .refValid(dRxValid), .refReady(dRxReady), .refData(dRxData), .cmdValid(cmdValid),
        .cmdData(cmdData), .paramValue(paramValue), .cmdAccepted(cmdAccepted),
        .cmdIgnored(cmdIgnored), .linkRunning(dRun), .refOverrun(dOvr), .voiceUnderrun(dUnd));
    vip_host_end #(.LOSS_CYCLES(LOSS)) vip_host_end_i (.clock(clock), .rst_n(rst_n),
        .clkEn(clkEn), .enable(hEn), .master(hMaster), .rate48k(hRate), .link(link),
        .refValid(hTxValid), .refReady(hTxReady), .refData(hTxData),
        .voiceValid(hRxValid), .voiceReady(hRxReady), .voiceData(hRxData),
        .linkRunning(hRun), .voiceOverrun(hOvr), .refUnderrun(hUnd));
    vip_link_props vip_link_props_i (.clock(clock), .rst_n(rst_n),
        .devBitClkOe(link.devBitClkOe), .hostBitClkOe(link.hostBitClkOe),
        .devFrameClkOe(link.devFrameClkOe), .hostFrameClkOe(link.hostFrameClkOe),
        .bitClk(link.bitClk), .frameChannelClock(link.frameChannelClock),
        .refSerial(link.refSerial), .voiceSerial(link.voiceSerial));
    // clock generator
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // collect words and host overrun pulses at the falling edge
    always @(negedge clock) begin
        if (dRxValid === 1'b1 && dRxReady === 1'b1) dQ.push_back(dRxData);
        if (hRxValid === 1'b1 && hRxReady === 1'b1) hQ.push_back(hRxData);
        if (hOvr === 1'b1) ovrSeen++;
    end
    task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic hang(input string what);
        fail_count++;
        $display("unexpected hang in %s: expected progress, seen none", what);
        results();
    endtask
    task automatic sendCmd(input logic [7:0] v, input logic acc, input logic [7:0] expP);
        @(posedge clock);
        cmdValid <= 1'b1;
        cmdData <= v;
        @(posedge clock);
        cmdValid <= 1'b0;
        @(negedge clock);
        check("cmdAccepted", 33'(acc), 33'(cmdAccepted));
        check("cmdIgnored", 33'(!acc), 33'(cmdIgnored));
        check("paramValue", 33'(expP), 33'(paramValue));
    endtask
    task automatic startLink(input logic devM, input logic r48);
        int i;
        @(posedge clock);
        dEn <= 1'b0;
        hEn <= 1'b0;
        repeat (4) @(posedge clock);
        dMaster <= devM;
        hMaster <= !devM;
        dRate <= r48;
        hRate <= r48;
        @(posedge clock);
        dEn <= 1'b1;
        hEn <= 1'b1;
        for (i = 0; i < 40000 && !(dRun === 1'b1 && hRun === 1'b1); i++) @(negedge clock);
        if (i == 40000) hang("link start");
    endtask
    task automatic holdFor(input logic lvl, inout int n);
        while (link.frameChannelClock === lvl && n < 40000) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic measFrame(input int expC);
        int n, h;
        n = 0;
        holdFor(1'b1, n);
        holdFor(1'b0, n);
        n = 0;
        holdFor(1'b1, n);
        h = n;
        holdFor(1'b0, n);
        check("frame period", 33'(expC), 33'((n >= expC - 1 && n <= expC + 1) ? expC : n));
        check("right half", 33'(1), 33'(2 * h - n <= 2 && n - 2 * h <= 2));
    endtask
    task automatic pushWords(input bit fromDev, input int n, input logic [31:0] b, output bit w);
        int k, i;
        w = 0;
        for (k = 0; k < n; k++) begin
            if (fromDev) begin
                dTxValid <= 1'b1;
                dTxData <= b + k;
            end else begin
                hTxValid <= 1'b1;
                hTxData <= b + k;
            end
            for (i = 0; i < 20000; i++) begin
                @(negedge clock);
                if ((fromDev ? dTxReady : hTxReady) === 1'b1) break;
                w = 1;
                @(posedge clock);
            end
            if (i == 20000) hang("push");
            @(posedge clock);
        end
        if (fromDev) dTxValid <= 1'b0;
        else hTxValid <= 1'b0;
    endtask
    task automatic cmpQ(input string what, input logic [32:0] q[$], input int n, input logic [31:0] b);
        int k = 0;
        logic ch = 1'b0;
        foreach (q[j]) begin
            if (q[j][31:0] !== 32'h0 && k < n) begin
                check(what, 33'(b + k), 33'(q[j][31:0]));
                if (k > 0) check("channel alternation", 33'(!ch), 33'(q[j][32]));
                ch = q[j][32];
                k++;
            end
        end
        check("word count", 33'(n), 33'(k));
    endtask
    task automatic exchange(input int n, input logic [31:0] vb, input logic [31:0] rb);
        int t;
        bit wd, wh;
        dQ.delete();
        hQ.delete();
        @(posedge clock);
        fork
            pushWords(1'b1, n, vb, wd);
            pushWords(1'b0, n, rb, wh);
        join
        for (t = 0; t < 40000 && (hQ.size() < n + 2 || dQ.size() < n + 2); t++) @(negedge clock);
        if (t == 40000) hang("exchange");
        cmpQ("voice word", hQ, n, vb);
        cmpQ("reference word", dQ, n, rb);
        if (n > 2) check("send refusal", 33'(1), 33'(wd && wh));
    endtask
    task automatic stallDrain();
        @(posedge clock);
        hRxReady <= 1'b0;
        ovrSeen = 0;
        repeat (2 * F48) @(posedge clock);
        @(negedge clock);
        check("overrun seen", 33'(1), 33'(ovrSeen > 0));
        hQ.delete();
        @(posedge clock);
        hRxReady <= 1'b1;
        repeat (4) @(negedge clock);
        check("drained words", 33'(2), 33'(hQ.size()));
        check("receive empty", 33'(0), 33'(hRxValid));
    endtask
    task automatic clockLoss();
        int i;
        @(posedge clock);
        hEn <= 1'b0;
        repeat (LOSS - 100) @(posedge clock);
        @(negedge clock);
        check("running held", 33'(1), 33'(dRun));
        for (i = 0; i < 300 && dRun !== 1'b0; i++) @(negedge clock);
        check("running dropped", 33'(0), 33'(dRun));
        sendCmd(8'h33, 1'b0, 8'hA5);
    endtask
    // main sequence
    initial begin
        {rst_n, dEn, dMaster, dRate, hEn, hMaster, hRate, dTxValid, hTxValid, cmdValid} = '0;
        {cmdData, dTxData, hTxData} = '0;
        {clkEn, dRxReady, hRxReady} = 3'h7;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        sendCmd(8'h5A, 1'b0, 8'h00);
        startLink(1'b1, 1'b0);
        exchange(2, 32'h8000_0001, 32'h0000_0F01);
        measFrame(F16);
        startLink(1'b0, 1'b1);
        measFrame(F48);
        exchange(4, 32'hC0DE_0001, 32'h1234_5601);
        sendCmd(8'hA5, 1'b1, 8'hA5);
        stallDrain();
        clockLoss();
        results();
    end
endmodule
`default_nettype wire
